// File: design/lio_cfg_pkg.sv
// constants and carrier types for the logical device configuration bank
package lio_cfg_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [1:0] DEV_PARALLEL = 2'h0;
   localparam logic [1:0] DEV_SERIAL_ONE = 2'h1;
   localparam logic [1:0] DEV_SERIAL_TWO = 2'h2;
   localparam int DEV_COUNT = 3;
   // byte address = {device[1:0], index[7:0], 2'b00}
   localparam int DEV_LSB = 10;
   localparam int IDX_LSB = 2;

   // ==========================================================
   // register indices; 30h, 60h and 61h exist in every device, the rest are device-private
   localparam logic [7:0] IDX_ACTIVATE = 8'h30;
   localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
   localparam logic [7:0] IDX_BASE_LOW = 8'h61;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_DMA = 8'h74;
   localparam logic [7:0] IDX_OPTION = 8'hf0;

   // ==========================================================
   // values after reset, element [n] belongs to device n
   localparam logic ACTIVATE_RST = 1'b1;
   localparam logic [DEV_COUNT-1:0][7:0] BASE_HIGH_RST =
      {8'h02, 8'h03, 8'h03};
   localparam logic [DEV_COUNT-1:0][7:0] BASE_LOW_RST =
      {8'hf8, 8'hf8, 8'h78};
   localparam logic [3:0] PAR_IRQ_RST = 4'h7;
   localparam logic [2:0] PAR_DMA_RST = 3'h4;
   localparam logic [6:0] PAR_OPTION_RST = 7'h3f;
   localparam logic [3:0] SER1_IRQ_RST = 4'h4;
   localparam logic [1:0] SER1_CLK_RST = 2'h0;

   // ==========================================================
   // field positions
   localparam int PAR_MODE_LSB = 0;
   localparam int PAR_THRESH_LSB = 3;
   localparam int PAR_ALIGN_BITS = 2;
   localparam int SER_ALIGN_BITS = 3;
   localparam int EPP_ALIGN_BIT = 2;
   localparam int DMA_OFF_BIT = 2;

   // ==========================================================
   // parallel port mode codes
   localparam logic [2:0] MODE_SPP = 3'h0;
   localparam logic [2:0] MODE_EPP19_SPP = 3'h1;
   localparam logic [2:0] MODE_ECP = 3'h2;
   localparam logic [2:0] MODE_ECP_EPP19 = 3'h3;
   localparam logic [2:0] MODE_PRINTER = 3'h4;
   localparam logic [2:0] MODE_EPP17_SPP = 3'h5;
   localparam logic [2:0] MODE_RESERVED = 3'h6;
   localparam logic [2:0] MODE_ECP_EPP17 = 3'h7;

   // ==========================================================
   // serial clock source: tick ratio numerator / denominator
   localparam logic [1:0] CLK_DIV13 = 2'h0;
   localparam logic [1:0] CLK_DIV12 = 2'h1;
   localparam logic [1:0] CLK_DIV1 = 2'h2;
   localparam logic [1:0] CLK_DIV1625 = 2'h3;
   localparam logic [3:0][4:0] CLK_NUM = {5'd8, 5'd1, 5'd1, 5'd1};
   localparam logic [3:0][4:0] CLK_DEN = {5'd13, 5'd1, 5'd12, 5'd13};

   // ==========================================================
   // carriers
   typedef struct packed {
      logic active;
      logic decode_en;
      logic [11:0] base;
      logic [3:0] irq;
      logic dma_on;
      logic [1:0] dma_chan;
      logic mode_valid;
      logic [2:0] mode;
      logic epp_on;
      logic ecp_on;
      logic [3:0] fifo_threshold;
   } parallel_cfg_t;

   typedef struct packed {
      logic active;
      logic decode_en;
      logic [11:0] base;
   } serial_cfg_t;

endpackage

// File: design/legacy_io_logical_device_config.sv
// configuration register bank for parallel port and two serial ports
//
// Operation
// RULE_01 - activation bit 0 enables each device; bits 7..1 reserved, read zero
// RULE_02 - parallel base 100h..FFCh on four bytes; no EPP when only four-aligned
// RULE_03 - parallel base on eight-byte boundary supports every mode, EPP included
// RULE_04 - parallel base registers reset to 03h and 78h, base 378h
// RULE_05 - parallel interrupt select in bits 3..0, upper reserved, reset 07h
// RULE_06 - parallel DMA codes 000..011 pick channel 0..3; 1xx no DMA; reset 04h
// RULE_07 - parallel mode field applies only while global override bit is zero
// RULE_08 - mode codes 000 SPP, 001 EPP1.9, 010 ECP, 011 ECP+EPP1.9, 100 printer
// RULE_09 - 101 EPP1.7, 111 ECP+EPP1.7, 110 reserved; register resets to 3Fh
// RULE_10 - first serial base 100h..FF8h on eight-byte boundary
// RULE_11 - first serial base registers reset to 03h and F8h, base 3F8h
// RULE_12 - first serial interrupt select in bits 3..0, upper reserved, reset 04h
// RULE_13 - first serial clock 24 MHz/13 for code 00, 24 MHz/12 for 01, reset 00h
// RULE_14 - second serial base 100h..FF8h on eight-byte boundary
// RULE_15 - second serial base registers reset to 02h and F8h, base 2F8h
// RULE_16 - 60h holds base high byte, 61h low byte; alignment bits ignored
// RULE_17 - clock code 10 gives undivided 24 MHz, 11 gives 24 MHz/1.625
// RULE_18 - mode register bits 6..3 stored and driven out as ECP FIFO threshold
`timescale 1ns/100ps
`default_nettype none

module legacy_io_logical_device_config
   import lio_cfg_pkg::*;
(
   // clock, reset, freeze
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clk_en,

   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [DATA_W-1:0] writedata,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,

   // global option register bit, same clock
   input wire logic global_mode_override_bit,

   // 24 MHz reference strobe, same clock
   input wire logic ref_tick,

   // decoded configuration
   output parallel_cfg_t parallel_port_cfg,
   output serial_cfg_t serial_one_cfg,
   output serial_cfg_t serial_two_cfg,
   output logic [3:0] serial_one_irq,
   output logic serial_one_clk_tick
);

   // ==========================================================
   // reset release
   logic rst_meta;
   logic rst_n;

   // async assert, release through two flops
   // rst_meta feeds rst_n only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // address decode
   logic [1:0] dev_sel;
   logic [7:0] idx;
   logic word_ok;
   logic wr_take;
   logic [7:0] wr_byte;

   // only lane 0 carries data; other lanes are ignored
   assign dev_sel = address[DEV_LSB +: 2];
   assign idx = address[IDX_LSB +: 8];
   // slot 3 and misaligned words are unmapped
   assign word_ok = (address[1:0] == 2'h0) &&
      (dev_sel != 2'h3);

   // a write lands where waitrequest is low
   assign wr_take = write && !waitrequest &&
      byteenable[0] && word_ok;
   assign wr_byte = writedata[7:0];

   // ==========================================================
   // per-device activation and base address
   logic [DEV_COUNT-1:0] activate;
   logic [7:0] base_high [DEV_COUNT];
   logic [7:0] base_low [DEV_COUNT];

   genvar g;
   generate
      for (g = 0; g < DEV_COUNT; g = g + 1) begin : gen_dev
         // one copy of the common registers per logical device
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               activate[g] <= ACTIVATE_RST; // RULE_01
               base_high[g] <= BASE_HIGH_RST[g]; // RULE_04 RULE_15
               base_low[g] <= BASE_LOW_RST[g]; // RULE_11
            end else if (clk_en && wr_take &&
               dev_sel == 2'(g)) begin
               // only the addressed device stores
               if (idx == IDX_ACTIVATE) begin
                  activate[g] <= wr_byte[0]; // RULE_01
               end

               if (idx == IDX_BASE_HIGH) begin
                  base_high[g] <= wr_byte; // RULE_16
               end
               if (idx == IDX_BASE_LOW) begin
                  base_low[g] <= wr_byte; // RULE_16
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // parallel port private registers
   logic [3:0] par_irq;
   logic [2:0] par_dma;
   logic [6:0] par_option;
   logic par_hit;

   // write strobe for the parallel port only
   assign par_hit = clk_en && wr_take &&
      dev_sel == DEV_PARALLEL;

   // interrupt line, DMA routing, mode and fifo threshold
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         par_irq <= PAR_IRQ_RST; // RULE_05
         par_dma <= PAR_DMA_RST; // RULE_06
         par_option <= PAR_OPTION_RST; // RULE_09
      end else if (par_hit) begin
         if (idx == IDX_IRQ) begin
            par_irq <= wr_byte[3:0]; // RULE_05
         end

         if (idx == IDX_DMA) begin
            par_dma <= wr_byte[2:0]; // RULE_06
         end

         if (idx == IDX_OPTION) begin
            par_option <= wr_byte[6:0]; // RULE_18
         end
      end
   end

   // ==========================================================
   // first serial port private registers
   logic [3:0] ser1_irq;
   logic [1:0] ser1_clk;
   logic ser1_hit;

   // write strobe for the first serial port only
   assign ser1_hit = clk_en && wr_take &&
      dev_sel == DEV_SERIAL_ONE;

   // interrupt line and clock source
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ser1_irq <= SER1_IRQ_RST; // RULE_12
         ser1_clk <= SER1_CLK_RST; // RULE_13
      end else if (ser1_hit) begin
         if (idx == IDX_IRQ) begin
            ser1_irq <= wr_byte[3:0]; // RULE_12
         end

         if (idx == IDX_OPTION) begin
            ser1_clk <= wr_byte[1:0]; // RULE_13
         end
      end
   end

   // ==========================================================
   // read mux; reserved bits and unmapped words read zero
   logic [7:0] next_rd;

   // dev_sel is safe to index once word_ok holds
   always_comb begin
      next_rd = 8'h00;
      if (word_ok) begin
         case (idx)
            IDX_ACTIVATE: next_rd = {7'h00, activate[dev_sel]}; // RULE_01
            IDX_BASE_HIGH: next_rd = base_high[dev_sel];
            IDX_BASE_LOW: next_rd = base_low[dev_sel];
            // device-private registers
            IDX_IRQ: begin
               if (dev_sel == DEV_PARALLEL) begin
                  next_rd = {4'h0, par_irq};
               end else if (dev_sel == DEV_SERIAL_ONE) begin
                  next_rd = {4'h0, ser1_irq};
               end
            end
            IDX_DMA: begin
               if (dev_sel == DEV_PARALLEL) begin
                  next_rd = {5'h00, par_dma};
               end
            end
            IDX_OPTION: begin
               if (dev_sel == DEV_PARALLEL) begin
                  next_rd = {1'b0, par_option};
               end else if (dev_sel == DEV_SERIAL_ONE) begin
                  next_rd = {6'h00, ser1_clk};
               end
            end
            default: next_rd = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // bus handshake: every access answers exactly one edge later
   // waitrequest idles high so no access completes in its first cycle
   // clk_en low stalls an access in flight
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else if (clk_en) begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // read data captured while waitrequest is still high
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= '0;
      end else if (clk_en && read && waitrequest) begin
         readdata <= {24'h000000, next_rd};
      end
   end

   // ==========================================================
   // decode helpers for the parallel port
   logic par_mode_valid;
   logic [2:0] par_mode;
   logic par_aligned8;
   logic par_ecp;

   // override bit hands mode control to the global register
   assign par_mode_valid = !global_mode_override_bit; // RULE_07
   assign par_mode = par_mode_valid ?
      par_option[PAR_MODE_LSB +: 3] : MODE_SPP; // RULE_07
   assign par_aligned8 = !base_low[DEV_PARALLEL][EPP_ALIGN_BIT]; // RULE_03

   // modes carrying an ECP engine; reserved code carries none
   always_comb begin
      case (par_mode)
         MODE_ECP: par_ecp = 1'b1; // RULE_08
         MODE_ECP_EPP19: par_ecp = 1'b1; // RULE_08
         MODE_ECP_EPP17: par_ecp = 1'b1; // RULE_09
         MODE_RESERVED: par_ecp = 1'b0; // RULE_09
         default: par_ecp = 1'b0;
      endcase
   end

   // ==========================================================
   // registered configuration for the parallel port
   // one cycle behind the registers; keeps outputs glitch free
   // base below 100h keeps decode off
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         parallel_port_cfg <= '0;
      end else if (clk_en) begin
         // enable and window
         parallel_port_cfg.active <= activate[DEV_PARALLEL]; // RULE_01
         parallel_port_cfg.decode_en <= activate[DEV_PARALLEL] &&
            base_high[DEV_PARALLEL][7:4] == 4'h0 &&
            base_high[DEV_PARALLEL][3:0] != 4'h0; // RULE_02
         parallel_port_cfg.base <= {base_high[DEV_PARALLEL][3:0],
            base_low[DEV_PARALLEL][7:PAR_ALIGN_BITS],
            2'b00}; // RULE_16

         // interrupt and dma routing
         parallel_port_cfg.irq <= par_irq; // RULE_05
         parallel_port_cfg.dma_on <= !par_dma[DMA_OFF_BIT]; // RULE_06
         parallel_port_cfg.dma_chan <= par_dma[1:0]; // RULE_06

         // mode selection
         parallel_port_cfg.mode_valid <= par_mode_valid; // RULE_07
         parallel_port_cfg.mode <= par_mode; // RULE_08
         // odd codes carry EPP, except at four-byte alignment
         parallel_port_cfg.epp_on <= par_mode_valid && par_mode[0] &&
            par_aligned8; // RULE_02
         parallel_port_cfg.ecp_on <= par_mode_valid && par_ecp; // RULE_08

         // ecp fifo threshold
         parallel_port_cfg.fifo_threshold <=
            par_option[PAR_THRESH_LSB +: 4]; // RULE_18
      end
   end

   // ==========================================================
   // registered configuration for both serial ports
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_one_cfg <= '0;
         serial_two_cfg <= '0;
         serial_one_irq <= SER1_IRQ_RST;
      end else if (clk_en) begin
         // first serial port
         serial_one_cfg.active <= activate[DEV_SERIAL_ONE];
         serial_one_cfg.decode_en <= activate[DEV_SERIAL_ONE] &&
            base_high[DEV_SERIAL_ONE][7:4] == 4'h0 &&
            base_high[DEV_SERIAL_ONE][3:0] != 4'h0; // RULE_10
         serial_one_cfg.base <= {base_high[DEV_SERIAL_ONE][3:0],
            base_low[DEV_SERIAL_ONE][7:SER_ALIGN_BITS],
            3'b000}; // RULE_10

         // second serial port
         serial_two_cfg.active <= activate[DEV_SERIAL_TWO];
         serial_two_cfg.decode_en <= activate[DEV_SERIAL_TWO] &&
            base_high[DEV_SERIAL_TWO][7:4] == 4'h0 &&
            base_high[DEV_SERIAL_TWO][3:0] != 4'h0; // RULE_14
         serial_two_cfg.base <= {base_high[DEV_SERIAL_TWO][3:0],
            base_low[DEV_SERIAL_TWO][7:SER_ALIGN_BITS],
            3'b000}; // RULE_14

         // first serial interrupt line
         serial_one_irq <= ser1_irq; // RULE_12
      end
   end

   // ==========================================================
   // first serial clock source: fractional divider on ref_tick
   // ratio num/den covers /13, /12, /1 and /1.625 with one adder
   // tick is an mclk strobe, not a clock
   logic [4:0] div_acc;
   logic [4:0] div_num;
   logic [4:0] div_den;
   logic [4:0] div_sum;

   // ratio picked by the stored code
   assign div_num = CLK_NUM[ser1_clk]; // RULE_17
   assign div_den = CLK_DEN[ser1_clk]; // RULE_13

   // acc below 13, num at most 8: sum fits
   assign div_sum = 5'(div_acc + div_num);

   // acc kept across code changes;
   // first period after a change may differ
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_acc <= 5'h00;
         serial_one_clk_tick <= 1'b0;
      end else if (clk_en) begin
         // low unless a carry occurs
         serial_one_clk_tick <= 1'b0;
         if (ref_tick) begin
            if (div_sum >= div_den) begin
               div_acc <= 5'(div_sum - div_den); // RULE_13
               serial_one_clk_tick <= 1'b1; // RULE_17
            end else begin
               div_acc <= div_sum;
            end
         end
      end
   end

endmodule

`default_nettype wire

// File: verif/lio_cfg_checker_assertions.sv
// port checks for the logical device configuration bank
`timescale 1ns/100ps
`default_nettype none

module lio_cfg_checker
   import lio_cfg_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   input wire logic clk_en,
   // register bus
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [DATA_W-1:0] readdata,
   input wire logic waitrequest,
   // side inputs
   input wire logic global_mode_override_bit,
   input wire logic ref_tick,
   // decoded outputs
   input wire parallel_cfg_t parallel_port_cfg,
   input wire serial_cfg_t serial_one_cfg,
   input wire serial_cfg_t serial_two_cfg,
   input wire logic [3:0] serial_one_irq,
   input wire logic serial_one_clk_tick
);
   // one clock domain, internal reset follows resetn
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // ==========================================================
   // bus handshake: answer within one or two edges, never a spurious answer
   a_ack_bounded: assert property ((read || write) && waitrequest && clk_en
      |-> ##[1:2] !waitrequest) else $error("request not answered");
   a_ack_single: assert property (!waitrequest |=> waitrequest)
      else $error("answer held longer than one cycle");
   a_ack_caused: assert property (!waitrequest |-> $past(read || write))
      else $error("answer without request");
   a_read_upper: assert property (readdata[31:8] == 24'h0)
      else $error("reserved read bits set");

   // ==========================================================
   // parallel port mode decode
   a_epp_align: assert property (parallel_port_cfg.epp_on ==
      (parallel_port_cfg.mode_valid && parallel_port_cfg.mode[0]
      && !parallel_port_cfg.base[2])) else $error("epp offer wrong");
   a_ecp_modes: assert property (parallel_port_cfg.ecp_on ==
      (parallel_port_cfg.mode_valid && (parallel_port_cfg.mode == MODE_ECP
      || parallel_port_cfg.mode == MODE_ECP_EPP19
      || parallel_port_cfg.mode == MODE_ECP_EPP17)))
      else $error("ecp offer wrong");
   a_override_mode: assert property (global_mode_override_bit
      && clk_en |=> !parallel_port_cfg.mode_valid)
      else $error("mode applied under override");
   a_mode_forced: assert property (!parallel_port_cfg.mode_valid
      |-> parallel_port_cfg.mode == MODE_SPP && !parallel_port_cfg.ecp_on)
      else $error("mode not forced to standard");

   // ==========================================================
   // base decode and clock ticks
   a_base_align: assert property (parallel_port_cfg.base[1:0] == 2'h0
      && serial_one_cfg.base[2:0] == 3'h0 && serial_two_cfg.base[2:0] == 3'h0)
      else $error("alignment bits not ignored");
   a_decode_range: assert property (parallel_port_cfg.decode_en
      |-> parallel_port_cfg.active && parallel_port_cfg.base[11:8] != 4'h0)
      else $error("decode enabled out of range");
   a_tick_cause: assert property (serial_one_clk_tick
      |-> $past(ref_tick) && $past(clk_en)) else $error("tick without ref");
   a_tick_pulse: assert property (serial_one_clk_tick |=> !serial_one_clk_tick)
      else $error("tick longer than one cycle");
endmodule

bind legacy_io_logical_device_config lio_cfg_checker chk_u (.mclk, .resetn,
   .clk_en, .address, .read, .write, .byteenable, .writedata, .readdata,
   .waitrequest, .global_mode_override_bit, .ref_tick, .parallel_port_cfg,
   .serial_one_cfg, .serial_two_cfg, .serial_one_irq, .serial_one_clk_tick);

`default_nettype wire

// File: verif/legacy_io_logical_device_config_bench.sv
// self-checking bench for the logical device configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module legacy_io_logical_device_config_bench;
   import lio_cfg_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hf;
   logic [DATA_W-1:0] writedata = '0;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   logic global_mode_override_bit = 1'b0;
   logic ref_tick = 1'b0;
   parallel_cfg_t pc;
   serial_cfg_t s1, s2;
   logic [3:0] s1_irq;
   logic s1_tick;
   int fail_count = 0;
   int n_tests = 0;
   int ticks = 0;
   logic [31:0] rd, old;
   logic [7:0] v, hi, lo, i;
   logic [3:0] t;
   logic [2:0] m;
   logic [1:0] d;
   logic e;
   logic [7:0] idx_tab [7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hf0, 8'h31};
   int exp_t [4] = '{12, 13, 156, 96};

   legacy_io_logical_device_config dut_u (.mclk(mclk), .resetn(resetn),
      .clk_en(clk_en), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest),
      .global_mode_override_bit(global_mode_override_bit),
      .ref_tick(ref_tick), .parallel_port_cfg(pc), .serial_one_cfg(s1),
      .serial_two_cfg(s2), .serial_one_irq(s1_irq),
      .serial_one_clk_tick(s1_tick));

   // ==========================================================
   // clock and tick counter
   always #4 mclk = ~mclk;
   always @(posedge mclk) if (s1_tick === 1'b1) ticks <= ticks + 1;

   // ==========================================================
   // bus master: holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [1:0] dv,
      input logic [7:0] ix, input logic [7:0] wd, input logic [3:0] be);
      int n = 0;
      @(posedge mclk);
      address <= {dv, ix, 2'h0};
      write <= wr;
      read <= ~wr;
      byteenable <= be;
      writedata <= {24'h0, wd};
      @(posedge mclk);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 20) fail_count++;
   endtask

   task automatic wr(input logic [1:0] dv, input logic [7:0] ix,
      input logic [7:0] wd);
      bus(1'b1, dv, ix, wd, 4'h1);
   endtask

   // ref strobes spaced like a 24 MHz rate, jittered
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         ref_tick <= 1'b1;
         @(posedge mclk);
         ref_tick <= 1'b0;
         repeat (3 + $urandom_range(3)) @(posedge mclk);
      end
   endtask

   // ==========================================================
   // expected register contents
   function automatic logic [7:0] msk(input logic [1:0] dv,
      input logic [7:0] ix);
      case (ix)
         IDX_ACTIVATE: msk = (dv == 2'h3) ? 8'h00 : 8'h01;
         IDX_BASE_HIGH, IDX_BASE_LOW: msk = (dv == 2'h3) ? 8'h00 : 8'hff;
         IDX_IRQ: msk = (dv < 2'h2) ? 8'h0f : 8'h00;
         IDX_DMA: msk = (dv == 2'h0) ? 8'h07 : 8'h00;
         IDX_OPTION: msk = (dv == 2'h0) ? 8'h7f : (dv == 2'h1) ? 8'h03 : 8'h00;
         default: msk = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] rstv(input logic [1:0] dv,
      input logic [7:0] ix);
      case (ix)
         IDX_ACTIVATE: rstv = 8'h01;
         IDX_BASE_HIGH: rstv = (dv == 2'h2) ? 8'h02 : 8'h03;
         IDX_BASE_LOW: rstv = (dv == 2'h0) ? 8'h78 : 8'hf8;
         IDX_IRQ: rstv = (dv == 2'h0) ? 8'h07 : 8'h04;
         IDX_DMA: rstv = 8'h04;
         IDX_OPTION: rstv = (dv == 2'h0) ? 8'h3f : 8'h00;
         default: rstv = 8'h00;
      endcase
      rstv = rstv & msk(dv, ix);
   endfunction

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog, well beyond the expected run of about 5k cycles
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      tally_and_finish;
   end

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'he76a));
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK("par_base0", 12'h378, pc.base)
      `CHK("s1_base0", 12'h3f8, s1.base)
      `CHK("s2_base0", 12'h2f8, s2.base)
      `CHK("par_mode0", MODE_ECP_EPP17, pc.mode)
      `CHK("s1_irq0", 4'h4, s1_irq)
      for (int k = 0; k < 28; k++) begin
         bus(1'b0, 2'(k / 7), idx_tab[k % 7], 8'h00, 4'hf);
         `CHK("reset_val", {24'h0, rstv(2'(k / 7), idx_tab[k % 7])}, rd)
      end
      // random writes, partial enables and unmapped places
      for (int k = 0; k < 30; k++) begin
         d = 2'($urandom_range(3));
         i = idx_tab[$urandom_range(6)];
         v = 8'($urandom);
         t = 4'($urandom);
         bus(1'b0, d, i, 8'h00, 4'hf);
         old = rd;
         bus(1'b1, d, i, v, t);
         bus(1'b0, d, i, 8'h00, 4'hf);
         `CHK("readback", t[0] ? {24'h0, v & msk(d, i)} : old, rd)
      end
      // every mode code twice, each time against a random base alignment
      wr(2'h0, IDX_BASE_HIGH, 8'h03);
      for (int k = 0; k < 16; k++) begin
         m = 3'(k);
         t = 4'($urandom);
         lo = 8'($urandom);
         wr(2'h0, IDX_OPTION, {1'b1, t, m});
         wr(2'h0, IDX_BASE_LOW, lo);
         repeat (2) @(posedge mclk);
         `CHK("par_base", {4'h3, lo[7:2], 2'h0}, pc.base)
         `CHK("par_mode", m, pc.mode)
         `CHK("par_epp", m[0] & ~lo[2], pc.epp_on)
         e = m inside {MODE_ECP, MODE_ECP_EPP19, MODE_ECP_EPP17};
         `CHK("par_ecp", e, pc.ecp_on)
         `CHK("par_fifo", t, pc.fifo_threshold)
      end
      global_mode_override_bit <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK("override", 4'h0, {pc.mode_valid, pc.mode})
      global_mode_override_bit <= 1'b0;
      // dma routing and interrupt selects
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         wr(2'h0, IDX_DMA, {5'h1f, 3'(k)});
         wr(2'h0, IDX_IRQ, v);
         wr(2'h1, IDX_IRQ, ~v);
         repeat (2) @(posedge mclk);
         `CHK("dma_on", ~k[2], pc.dma_on)
         if (k < 4) `CHK("dma_chan", 2'(k), pc.dma_chan)
         `CHK("par_irq", v[3:0], pc.irq)
         `CHK("s1_irq", ~v[3:0], s1_irq)
      end
      // activation and base decode on all three devices
      for (int k = 0; k < 8; k++) begin
         v = {7'($urandom), k[0]};
         hi = (k < 2) ? 8'(k * 16) : 8'($urandom_range(15));
         lo = 8'($urandom);
         for (int n = 0; n < 3; n++) begin
            wr(2'(n), IDX_ACTIVATE, v);
            wr(2'(n), IDX_BASE_HIGH, hi);
            wr(2'(n), IDX_BASE_LOW, lo);
         end
         repeat (2) @(posedge mclk);
         e = v[0] & (hi[7:4] == 4'h0) & (hi[3:0] != 4'h0);
         `CHK("active", v[0], s2.active)
         `CHK("par_act", v[0], pc.active)
         `CHK("s1_act", v[0], s1.active)
         `CHK("s2_dec", e, s2.decode_en)
         `CHK("par_dec", e, pc.decode_en)
         `CHK("s1_dec", e, s1.decode_en)
         `CHK("s1_base", {hi[3:0], lo[7:3], 3'h0}, s1.base)
         `CHK("s2_base", {hi[3:0], lo[7:3], 3'h0}, s2.base)
      end
      // clock source codes, settle then count over 156 strobes
      for (int k = 0; k < 4; k++) begin
         wr(2'h1, IDX_OPTION, 8'(k));
         pulses(13);
         ticks = 0;
         pulses(156);
         `CHK("ticks", exp_t[k], ticks)
      end
      // frozen clock enable drops strobes
      @(posedge mclk);
      clk_en <= 1'b0;
      ticks = 0;
      pulses(5);
      clk_en <= 1'b1;
      `CHK("frozen", 0, ticks)
      // second reset in mid-run
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      bus(1'b0, 2'h0, IDX_BASE_LOW, 8'h00, 4'hf);
      `CHK("rereset", 32'h78, rd)
      tally_and_finish;
   end
endmodule

`default_nettype wire
